// ===== rtl/sbk_pkg.sv
// constants and types for the bank-0 special function register block
// Behaviour
// - shared core registers decode in every bank
// - upper program counter byte has no mapping
// - buffer feeds counter bits 12..8 on load
// - other resets load second reset column
// - unchanged bits keep, cause bits follow reset
// - unimplemented locations and bits read zero
package sbk_pkg;

    localparam int SBK_LOCS = 32;

    // register locations, byte address is four times these
    localparam logic [4:0] LOC_INDIRECT      = 5'h00;
    localparam logic [4:0] LOC_TIMER0_COUNT  = 5'h01;
    localparam logic [4:0] LOC_PC_LOW        = 5'h02;
    localparam logic [4:0] LOC_STATUS        = 5'h03;
    localparam logic [4:0] LOC_POINTER       = 5'h04;
    localparam logic [4:0] LOC_PORT_A        = 5'h05;
    localparam logic [4:0] LOC_PORT_B        = 5'h06;
    localparam logic [4:0] LOC_PORT_C        = 5'h07;
    localparam logic [4:0] LOC_PORT_D        = 5'h08;
    localparam logic [4:0] LOC_PORT_E        = 5'h09;
    localparam logic [4:0] LOC_PC_HIGH_BUF   = 5'h0a;
    localparam logic [4:0] LOC_INT_CONTROL   = 5'h0b;
    localparam logic [4:0] LOC_FLAGS_1       = 5'h0c;
    localparam logic [4:0] LOC_FLAGS_2       = 5'h0d;
    localparam logic [4:0] LOC_TIMER1_LOW    = 5'h0e;
    localparam logic [4:0] LOC_TIMER1_HIGH   = 5'h0f;
    localparam logic [4:0] LOC_TIMER1_CTRL   = 5'h10;
    localparam logic [4:0] LOC_TIMER2_COUNT  = 5'h11;
    localparam logic [4:0] LOC_TIMER2_CTRL   = 5'h12;
    localparam logic [4:0] LOC_SERIAL_BUF    = 5'h13;
    localparam logic [4:0] LOC_SERIAL_CTRL   = 5'h14;
    localparam logic [4:0] LOC_CCP1_LOW      = 5'h15;
    localparam logic [4:0] LOC_CCP1_HIGH     = 5'h16;
    localparam logic [4:0] LOC_CCP1_CTRL     = 5'h17;
    localparam logic [4:0] LOC_UART_RX_STAT  = 5'h18;
    localparam logic [4:0] LOC_UART_TX_DATA  = 5'h19;
    localparam logic [4:0] LOC_UART_RX_DATA  = 5'h1a;
    localparam logic [4:0] LOC_CCP2_LOW      = 5'h1b;
    localparam logic [4:0] LOC_CCP2_HIGH     = 5'h1c;
    localparam logic [4:0] LOC_CCP2_CTRL     = 5'h1d;
    localparam logic [4:0] LOC_ADC_RESULT    = 5'h1e;
    localparam logic [4:0] LOC_ADC_CTRL      = 5'h1f;

    // status field positions
    localparam int IND_BANK_BIT   = 7;
    localparam int UPPER_BANK_BIT = 6;
    localparam int LOWER_BANK_BIT = 5;
    localparam int TIMEOUT_BIT    = 4;
    localparam int POWERDOWN_BIT  = 3;

    localparam int PC_W  = 13;
    localparam int BUF_W = 5;

    // power-up value of status; every other location powers up zero
    localparam logic [7:0] STATUS_POR = 8'h18;

    // locations visible from any bank
    localparam logic [31:0] SBK_SHARED = 32'h00000c1d;

    // implemented bits per location, indexed by location
    localparam logic [0:31][7:0] SBK_RD_MASK = {
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'hff, 8'h07, 8'h1f, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff,
        8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
        8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hfd};

    // bits stored from a bus write
    localparam logic [0:31][7:0] SBK_WR_MASK = {
        8'h00, 8'hff, 8'h00, 8'he7, 8'hff, 8'h3f, 8'hff, 8'hff,
        8'hff, 8'h07, 8'h1f, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff,
        8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
        8'hf7, 8'hff, 8'h00, 8'hff, 8'hff, 8'h3f, 8'h00, 8'hfd};

    // bits left unchanged by a non-power-up reset
    localparam logic [0:31][7:0] SBK_KEEP_MASK = {
        8'h00, 8'hff, 8'h00, 8'h07, 8'hff, 8'h10, 8'hff, 8'hff,
        8'hff, 8'h07, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff,
        8'h3f, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00};

    // indirect data memory access toward the core
    typedef struct packed {
        logic       we;
        logic [8:0] addr;
        logic [7:0] wdata;
    } sbk_ind_t;

    // bus data phase held from the address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       map;
        logic [4:0] loc;
    } sbk_dph_t;

endpackage : sbk_pkg

// ===== rtl/sbk_regs.sv
// bank-0 special function register block behind an ahb-lite slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
module sbk_regs
    import sbk_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [ADDR_W-1:0]       haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic                    soft_reset,
    input  wire logic                    soft_reset_timeout,
    input  wire logic                    soft_reset_powerdown,
    input  wire logic                    pc_step,
    output logic [PC_W-1:0]              pc_value,
    output sbk_ind_t                     indirect,
    input  wire logic [7:0]              indirect_rdata,
    input  wire logic [4:0][7:0]         port_pins,
    input  wire logic [7:0]              rx_data_in,
    input  wire logic [7:0]              adc_result_in,
    input  wire logic [8:0]              flag_set,
    output logic [0:31][7:0]             sfr_image
);

    // the top address bits must exist above the location field
    generate
        if (ADDR_W < 8) begin : g_bad_width
            $error("sbk_regs: ADDR_W must be at least 8");
        end
    endgenerate

    logic [0:31][7:0] regs;          // register storage
    logic [PC_W-1:0]  pc;            // full program counter
    sbk_dph_t         dph;           // pending data phase
    logic [4:0][7:0]  pin_meta;      // first sync stage
    logic [4:0][7:0]  pin_sync;      // second sync stage
    logic             ind_we;        // indirect write pulse
    logic [7:0]       ind_wdata;     // indirect write data
    logic [7:0]       rd_byte;       // selected read byte
    logic [7:0]       next_flags_1;  // peripheral flags after write
    logic             next_flags_2;  // second flag after write

    // address and data phase decode
    logic             a_valid;       // transfer offered and taken
    logic [4:0]       a_loc;         // location within bank
    logic [1:0]       bank;          // current direct bank
    logic             a_map;         // location exists here
    logic             wr_now;        // write completes this cycle
    logic             wr_pcl;        // low counter byte written
    logic             ptr_zero;      // pointer aims at itself

    // always ready, always okay: every access ends in one cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign a_valid = hsel && hready && htrans[1];
    // low address bits pick one of 32 slots in the bank
    assign a_loc   = haddr[6:2];
    // both bank bits take part; rp1 stays clear on small parts
    assign bank    = {regs[LOC_STATUS][UPPER_BANK_BIT],
                      regs[LOC_STATUS][LOWER_BANK_BIT]};

    // shared core registers answer in every bank
    // other banks are not held here, so they read as empty
    assign a_map = (haddr[ADDR_W-1:7] == '0)
                && (haddr[1:0] == 2'b00)
                && ((bank == 2'b00) || SBK_SHARED[a_loc]);

    assign wr_now   = dph.wr && dph.map && !soft_reset;
    assign wr_pcl   = wr_now && (dph.loc == LOC_PC_LOW);
    assign ptr_zero = ({regs[LOC_STATUS][IND_BANK_BIT],
                        regs[LOC_POINTER]} == 9'h000);

    // capture the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph <= '0;
        end else if (hready) begin
            dph.wr  <= a_valid && hwrite;
            dph.rd  <= a_valid && !hwrite;
            dph.map <= a_map;
            dph.loc <= a_loc;
        end
    end

    // port pins come from outside; two stages before any use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= port_pins;
            pin_sync <= pin_meta;
        end
    end

    // flag registers: hardware set wins over a software clear
    always_comb begin
        next_flags_1 = regs[LOC_FLAGS_1];
        next_flags_2 = regs[LOC_FLAGS_2][0];
        if (wr_now && (dph.loc == LOC_FLAGS_1)) begin
            next_flags_1 = hwdata[7:0];
        end
        if (wr_now && (dph.loc == LOC_FLAGS_2)) begin
            next_flags_2 = hwdata[0];
        end
        next_flags_1 = next_flags_1 | flag_set[7:0];
        next_flags_2 = next_flags_2 | flag_set[8];
    end

    // register storage, two reset columns and bus writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // power-up column; unknown bits settle at zero
            for (int i = 0; i < SBK_LOCS; i++) begin
                regs[i] <= 8'h00;
            end
            regs[LOC_STATUS] <= STATUS_POR;
        end else if (soft_reset) begin
            // second column: clear all but the unchanged bits
            for (int i = 0; i < SBK_LOCS; i++) begin
                regs[i] <= regs[i] & SBK_KEEP_MASK[i];
            end
            // cause bits follow the kind of reset
            regs[LOC_STATUS][TIMEOUT_BIT]   <= soft_reset_timeout;
            regs[LOC_STATUS][POWERDOWN_BIT] <= soft_reset_powerdown;
        end else begin
            // only implemented, writable bits take bus data
            if (wr_now) begin
                regs[dph.loc] <= (regs[dph.loc] & ~SBK_WR_MASK[dph.loc])
                               | (hwdata[7:0] & SBK_WR_MASK[dph.loc]);
            end
            // later assignment wins for the flag locations
            regs[LOC_FLAGS_1] <= next_flags_1;
            regs[LOC_FLAGS_2] <= {7'h00, next_flags_2};
        end
    end

    // program counter; upper byte never reached by the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= '0;
        end else if (soft_reset) begin
            pc <= '0;
        end else if (wr_pcl) begin
            // buffer moves into bits 12..8 only on a load
            pc <= {regs[LOC_PC_HIGH_BUF][BUF_W-1:0], hwdata[7:0]};
        end else if (pc_step) begin
            pc <= pc + 13'h0001;
        end
    end

    // indirect writes go to data memory, not to a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ind_we    <= 1'b0;
            ind_wdata <= 8'h00;
        end else begin
            // the pointer aiming at itself makes the write a no-op
            ind_we <= wr_now && (dph.loc == LOC_INDIRECT) && !ptr_zero;
            if (wr_now && (dph.loc == LOC_INDIRECT)) begin
                ind_wdata <= hwdata[7:0];
            end
        end
    end

    assign indirect.we    = ind_we;
    assign indirect.addr  = {regs[LOC_STATUS][IND_BANK_BIT],
                             regs[LOC_POINTER]};
    assign indirect.wdata = ind_wdata;

    // read mux; runs in the data phase so a write just before shows
    always_comb begin
        rd_byte = 8'h00;
        if (dph.rd && dph.map) begin
            case (dph.loc)
                // indirect read through the pointer, zero on itself
                LOC_INDIRECT: begin
                    rd_byte = ptr_zero ? 8'h00 : indirect_rdata;
                end
                LOC_PC_LOW: begin
                    rd_byte = pc[7:0];
                end
                // ports read the pins, not the latch
                LOC_PORT_A: begin
                    rd_byte = pin_sync[0];
                end
                LOC_PORT_B: begin
                    rd_byte = pin_sync[1];
                end
                LOC_PORT_C: begin
                    rd_byte = pin_sync[2];
                end
                LOC_PORT_D: begin
                    rd_byte = pin_sync[3];
                end
                LOC_PORT_E: begin
                    rd_byte = pin_sync[4];
                end
                // transmit data is write only
                LOC_UART_TX_DATA: begin
                    rd_byte = 8'h00;
                end
                LOC_UART_RX_DATA: begin
                    rd_byte = rx_data_in;
                end
                LOC_ADC_RESULT: begin
                    rd_byte = adc_result_in;
                end
                default: begin
                    rd_byte = regs[dph.loc];
                end
            endcase
            // missing bit positions read zero
            rd_byte = rd_byte & SBK_RD_MASK[dph.loc];
        end
    end

    // upper lanes are never implemented
    assign hrdata    = {24'h000000, rd_byte};
    assign pc_value  = pc;
    assign sfr_image = regs;

    // checks kept beside the logic they watch

    chk_shared_decode:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (a_valid && hwrite && a_map && (bank != 2'b00)
         && (a_loc == LOC_PC_HIGH_BUF)) ##1 !soft_reset
        |=> regs[LOC_PC_HIGH_BUF][4:0] == $past(hwdata[4:0]))
    else $error("shared buffer not written from other bank");

    chk_bank_decode:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (a_valid && hwrite && (bank != 2'b00)
         && (a_loc == LOC_TIMER2_COUNT)) ##1 !soft_reset
        |=> regs[LOC_TIMER2_COUNT] == $past(regs[LOC_TIMER2_COUNT]))
    else $error("bank-0 register written from another bank");

    chk_pc_high_hidden:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (!wr_pcl && !pc_step && !soft_reset)
        |=> $stable(pc_value[12:8]))
    else $error("upper counter bits moved without a load");

    chk_buffer_load:
    assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pcl |=> pc_value == {$past(regs[LOC_PC_HIGH_BUF][4:0]),
                                $past(hwdata[7:0])})
    else $error("counter load did not take the buffer");

    chk_soft_reset_vals:
    assert property (@(posedge hclk) disable iff (!hresetn)
        soft_reset |=> (pc_value == 13'h0000)
                    && (regs[LOC_PC_HIGH_BUF] == 8'h00)
                    && (regs[LOC_STATUS][7:5] == 3'b000)
                    && (regs[LOC_TIMER2_CTRL] == 8'h00))
    else $error("second reset column not applied");

    chk_keep_bits:
    assert property (@(posedge hclk) disable iff (!hresetn)
        soft_reset |=> (regs[LOC_POINTER] == $past(regs[LOC_POINTER]))
            && (regs[LOC_STATUS][TIMEOUT_BIT]
                == $past(soft_reset_timeout))
            && (regs[LOC_STATUS][2:0] == $past(regs[LOC_STATUS][2:0])))
    else $error("reset lost a kept bit or a cause bit");

    chk_unmapped_zero:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (dph.rd && !dph.map) |-> hrdata == 32'h00000000)
    else $error("unmapped read returned data");

    chk_unimpl_bits:
    assert property (@(posedge hclk) disable iff (!hresetn)
        dph.rd |-> ((hrdata[7:0] & ~SBK_RD_MASK[dph.loc]) == 8'h00)
                && (hrdata[31:8] == 24'h000000))
    else $error("unimplemented bit read as one");

    chk_flag_set_wins:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (flag_set[0] && !soft_reset) |=> regs[LOC_FLAGS_1][0])
    else $error("flag set lost against a clear");

endmodule : sbk_regs

// ===== test/sbk_regs_tb.sv
// self-checking bench for the bank-0 register block
`timescale 1ns/100ps
module testbench
    import sbk_pkg::*;
;
    logic                hclk = 1'b0;
    logic                hresetn = 1'b0;
    logic                hsel = 1'b0;
    logic [11:0]         haddr = 12'h000;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [2:0]          hsize = 3'h2;      // whole words only
    logic [31:0]         hwdata = 32'h0;
    logic                hready;
    logic                hreadyout;
    logic                hresp;
    logic [31:0]         hrdata;
    logic                soft_reset = 1'b0;
    logic                soft_reset_timeout = 1'b0;
    logic                soft_reset_powerdown = 1'b0;
    logic                pc_step = 1'b0;
    logic [PC_W-1:0]     pc_value;
    sbk_ind_t            indirect;
    logic [7:0]          indirect_rdata = 8'h00;
    logic [4:0][7:0]     port_pins = '0;
    logic [7:0]          rx_data_in = 8'h00;
    logic [7:0]          adc_result_in = 8'h00;
    logic [8:0]          flag_set = 9'h000;
    logic [0:31][7:0]    sfr_image;
    logic [7:0]          m [0:31];          // expected storage image
    logic [PC_W-1:0]     pc;                // expected program counter
    logic [31:0]         r;                 // random draw
    logic [31:0]         d;                 // random write data
    int                  n_fail = 0;
    int                  cmp_count = 0;
    int                  seed = 32'h9d1e;

    // 50 ns period; the single slave's ready is the bus ready
    always #25 hclk = ~hclk;
    assign hready = hreadyout;

    sbk_regs #(.ADDR_W(12)) i_sbk_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset),
        .soft_reset_timeout(soft_reset_timeout),
        .soft_reset_powerdown(soft_reset_powerdown),
        .pc_step(pc_step), .pc_value(pc_value), .indirect(indirect),
        .indirect_rdata(indirect_rdata), .port_pins(port_pins),
        .rx_data_in(rx_data_in), .adc_result_in(adc_result_in),
        .flag_set(flag_set), .sfr_image(sfr_image));

    // verdict and end of run, also reached by an expired wait
    task automatic print_verdict;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // one compare for every kind of value
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // hold a phase until hready is sampled high at a rising edge
    // the answer is taken at that same edge, before any flop moves
    task automatic wait_ready(output logic [31:0] rd);
        logic rdy;
        rdy = 1'b0;
        rd = '0;
        for (int i = 0; i < 16 && !rdy; i++) begin
            @(posedge hclk);
            rd = hrdata;
            rdy = (hready === 1'b1);
        end
        if (!rdy) begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_ready

    // single ahb-lite transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        logic [31:0] dummy;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready(dummy);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready(rd);
        chk("hresp", 32'h0, 32'(hresp));
    endtask : xfer

    // decode as seen in the address phase
    function automatic logic mapped(input logic [11:0] a);
        return a[11:7] == 5'h00 && a[1:0] == 2'h0 &&
               (m[3][6:5] == 2'h0 || SBK_SHARED[a[6:2]]);
    endfunction : mapped

    // expected read byte for a byte address
    function automatic logic [7:0] exp_rd(input logic [11:0] a);
        logic [4:0] l;
        l = a[6:2];
        if (!mapped(a)) return 8'h00;
        if (l == LOC_UART_TX_DATA) return 8'h00;
        if (l == LOC_INDIRECT) return {m[3][7], m[4]} != 0 ? indirect_rdata : 8'h00;
        if (l == LOC_PC_LOW) return pc[7:0];
        if (l == LOC_UART_RX_DATA) return rx_data_in;
        if (l == LOC_ADC_RESULT) return adc_result_in;
        if (l >= LOC_PORT_A && l <= LOC_PORT_E)
            return port_pins[l - LOC_PORT_A] & SBK_RD_MASK[l];
        return m[l] & SBK_RD_MASK[l];
    endfunction : exp_rd

    // outputs against the model at the falling edge after an operation
    task automatic chk_state(input logic we, input logic [7:0] wd);
        @(negedge hclk);
        chk("pc_value", 32'(pc), 32'(pc_value));
        chk("hrdata idle", 32'h0, hrdata);
        for (int i = 0; i < SBK_LOCS; i++)
            chk("sfr_image", 32'(m[i]), 32'(sfr_image[i]));
        chk("indirect.we", 32'(we), 32'(indirect.we));
        if (we) chk("indirect", {14'h0, 1'b1, m[3][7], m[4], wd}, 32'(indirect));
        @(posedge hclk);
    endtask : chk_state

    // bus access with model update and checks
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        logic [31:0] rd;
        logic [7:0]  e;
        logic        ok;
        logic        we;
        logic [4:0]  l;
        l = a[6:2];
        ok = mapped(a);
        e = exp_rd(a);
        we = wr && ok && l == LOC_INDIRECT && {m[3][7], m[4]} != 0;
        xfer(wr, a, d, rd);
        // write-only transmit data reads back as zero
        if (!wr)
            chk("hrdata", {24'h0, e}, rd);
        if (wr && ok) begin
            m[l] = (m[l] & ~SBK_WR_MASK[l]) | (d[7:0] & SBK_WR_MASK[l]);
            if (l == LOC_PC_LOW) pc = {m[LOC_PC_HIGH_BUF][4:0], d[7:0]};
        end
        chk_state(we, d[7:0]);
    endtask : bus

    // power-up reset: 3 cycles low
    task automatic por;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (m[i]) m[i] = 8'h00;
        m[3] = STATUS_POR;
        pc = '0;
        chk_state(1'b0, 8'h00);
    endtask : por

    // master-clear or watchdog reset, one edge
    task automatic other_reset(input logic to, input logic pd);
        soft_reset_timeout <= to;
        soft_reset_powerdown <= pd;
        soft_reset <= 1'b1;
        @(posedge hclk);
        soft_reset <= 1'b0;
        foreach (m[i]) m[i] = m[i] & SBK_KEEP_MASK[i];
        m[3] = m[3] | {3'h0, to, pd, 3'h0};
        pc = '0;
        chk_state(1'b0, 8'h00);
    endtask : other_reset

    // read the whole bank
    task automatic read_all;
        for (int i = 0; i < SBK_LOCS; i++) bus(1'b0, 12'(i * 4), 32'h0);
    endtask : read_all

    initial begin
        r = $random(seed);
        port_pins <= {$random(seed), r[7:0]};
        rx_data_in <= r[15:8];
        adc_result_in <= r[23:16];
        indirect_rdata <= r[31:24];
        @(posedge hclk);
        por();
        read_all();
        // upper counter bits load only through the buffer
        bus(1'b1, 12'h028, 32'hffff_ff15);
        chk("pc after buffer", 32'h0, 32'(pc_value));
        bus(1'b1, 12'h008, 32'h0000_00a7);
        pc_step <= 1'b1;
        @(posedge hclk);
        pc_step <= 1'b0;
        pc = pc + 1'b1;
        chk_state(1'b0, 8'h00);
        bus(1'b0, 12'h008, 32'h0);
        // other bank: shared places stay, the rest vanish
        bus(1'b1, 12'h00c, 32'h0000_0020);
        bus(1'b1, 12'h044, 32'h0000_005a);
        bus(1'b0, 12'h044, 32'h0);
        bus(1'b1, 12'h028, 32'h0000_000c);
        bus(1'b1, 12'h010, 32'h0000_0031);
        bus(1'b0, 12'h02c, 32'h0);
        bus(1'b1, 12'h00c, 32'h0000_0000);
        // outside the map and misaligned
        bus(1'b1, 12'h0c4, 32'h0000_00ff);
        bus(1'b0, 12'h0c4, 32'h0);
        bus(1'b1, 12'h046, 32'h0000_00ff);
        // indirect access through a nonzero pointer
        bus(1'b1, 12'h010, 32'h0000_0042);
        bus(1'b1, 12'h000, 32'h0000_0099);
        bus(1'b0, 12'h000, 32'h0);
        // peripheral flags set from outside
        flag_set <= 9'h1a5;
        @(posedge hclk);
        flag_set <= 9'h000;
        m[LOC_FLAGS_1] = m[LOC_FLAGS_1] | 8'ha5;
        m[LOC_FLAGS_2] = m[LOC_FLAGS_2] | 8'h01;
        chk_state(1'b0, 8'h00);
        // random traffic with all bank settings of the small variant
        for (int n = 0; n < 300; n++) begin
            r = $random(seed);
            d = $random(seed);
            // reserved bank bits stay clear on the small variant
            if (r[8:4] == LOC_STATUS) d[7:6] = 2'h0;
            bus(r[9], {r[3:0] == 4'h0 ? 5'h01 : 5'h00, r[8:4],
                r[12:10] == 3'h0 ? r[14:13] : 2'h0}, d);
        end
        other_reset(r[1], r[2]);
        read_all();
        other_reset(~r[1], ~r[2]);
        por();
        read_all();
        print_verdict();
    end
endmodule : testbench
